// *** pkg/ppt_pkg.sv ***
// Purpose: constants shared by the three-port parallel i/o block
// Assumes: one aligned 32-bit word per register, byte address = 4 * printed index
// Notes: printed offsets are not all multiples of four, so they are kept as indices
package ppt_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] IDX_SLAVE_LINK_CONTROL = 8'h24;
   localparam logic [7:0] IDX_BYTE_PORT_DATA = 8'h30;
   localparam logic [7:0] IDX_SIX_IN_TWO_OUT_DATA = 8'h40;
   localparam logic [7:0] IDX_SPLIT_PORT_DATA = 8'h50;
   localparam logic [7:0] IDX_SPLIT_PORT_FUNCTION_SELECT = 8'h55;
   localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h58;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] ADDR_SLC = {IDX_SLAVE_LINK_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_BPD = {IDX_BYTE_PORT_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SIT = {IDX_SIX_IN_TWO_OUT_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SPD = {IDX_SPLIT_PORT_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SPF = {IDX_SPLIT_PORT_FUNCTION_SELECT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SER = {IDX_SERIAL_CONTROL, 2'b00};

   // ****************************************************************
   // field values and layouts
   // ****************************************************************
   localparam logic [7:0] SLC_PORT_IN = 8'h80;
   localparam logic [7:0] SLC_PORT_OUT = 8'h84;
   localparam logic [7:0] SLC_RESET = 8'h00;
   localparam int SLC_DIR_BIT = 2;
   localparam int SLC_SLAVE_LSB = 0;
   localparam int SLC_SLAVE_W = 2;
   localparam logic [7:0] EVEN_MASK = 8'h55;
   localparam logic [7:0] ODD_MASK = 8'haa;
   localparam logic [7:0] PB_OUT_MASK = 8'hc0;
   localparam logic [7:0] PB_IN_MASK = 8'h3f;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int PB_LINE_SIX = 6;
   localparam int PB_LINE_SEVEN = 7;
   localparam int PB_LINE_ZERO = 0;
   localparam int PB_LINE_ONE = 1;
   // serial control (chosen layout)
   localparam int SER_A_CLK_BIT = 0;
   localparam int SER_B_CLK_BIT = 1;
   localparam int SER_A_ALT_BIT = 2;
   localparam int SER_B_ALT_BIT = 3;
   localparam logic [3:0] SER_RESET = 4'h0;
   // split port pin positions
   localparam int PC_TX_A = 6;
   localparam int PC_TX_B = 4;
   localparam int PC_TX_C = 2;
   localparam int PC_TX_D = 0;
   localparam int PC_RX_A = 7;
   localparam int PC_RX_B = 5;
   localparam int PD_RX_A = 7;
   localparam int PD_RX_B = 5;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;

   // ****************************************************************
   // bus slave states
   // ****************************************************************
   typedef enum logic [0:0] {
      PPT_IDLE = 1'b0,
      PPT_DATA = 1'b1
   } ppt_phase_e;
endpackage

// *** hdl/ppt_line_mux.sv ***
// Purpose: per-line selection of drive source for a group of output lines
// Assumes: sel high routes the alternate signal, low routes the register bit
// Notes: the drive result is what the even bits of a read echo
`timescale 1ns/100ps
module ppt_line_mux #(
   parameter int W = 8
) (
   // selection
   input wire logic [W-1:0] sel,
   input wire logic [W-1:0] reg_val,
   input wire logic [W-1:0] alt_val,
   // result
   output logic [W-1:0] drive
);
   always_comb begin
      for (int i = 0; i < W; i++) begin
         drive[i] = sel[i] ? alt_val[i] : reg_val[i];
      end
   end
endmodule

// *** hdl/ppt_serial_rx_sel.sv ***
// Purpose: choose receive source for serial ports a and b
// Assumes: pin levels synchronous to hclk
// Notes: c and d receivers always use split port pins
`timescale 1ns/100ps
module ppt_serial_rx_sel (
   // source select
   input wire logic alt_a,
   input wire logic alt_b,
   // pins
   input wire logic [7:0] split_in,
   input wire logic [7:0] fourth_in,
   // receive lines
   output logic rx_a,
   output logic rx_b
);
   always_comb begin
      rx_a = alt_a ? fourth_in[ppt_pkg::PD_RX_A] : split_in[ppt_pkg::PC_RX_A];
      rx_b = alt_b ? fourth_in[ppt_pkg::PD_RX_B] : split_in[ppt_pkg::PC_RX_B];
   end
endmodule

// *** hdl/ppt_ports.sv ***
// Purpose: three 8-bit parallel ports behind an ahb-lite register slave
// Assumes: pins synchronous to hclk; zero-wait single word transfers
// Notes: slave and serial internals live elsewhere, only their lines meet here
//
// How it works
// - byte port register: write stores, read returns pins
// - control value 0x080 makes byte port input
// - control value 0x084 drives byte port output
// - after reset byte port is undriven input
// - byte port read shows sampled pin levels
// - second port: six inputs, two echoed outputs
// - slave mode: lines 2-7 slave, reads remain
// - lines 0/1 carry serial clocks when enabled
// - reset drives second port lines 6,7 low
// - split port even outputs, odd inputs, echo
// - function bits route transmit lines to outputs
// - serial receive lines stay readable on split port
// - serial a/b receive may come from fourth port
// - reset zeroes split even data and function bits
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
module ppt_ports (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [ppt_pkg::ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // byte port pins
   input wire logic [7:0] byte_port_in,
   output logic [7:0] byte_port_out,
   output logic [7:0] byte_port_oe,
   // second port pins
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_out,
   output logic [7:0] second_port_oe,
   // split port pins and fourth port receive pins
   input wire logic [7:0] split_port_in,
   output logic [7:0] split_port_out,
   input wire logic [7:0] fourth_port_in,
   // serial unit lines
   input wire logic serial_a_transmit,
   input wire logic serial_b_transmit,
   input wire logic serial_c_transmit,
   input wire logic serial_d_transmit,
   input wire logic serial_a_clk_out,
   input wire logic serial_b_clk_out,
   output logic serial_a_rx,
   output logic serial_b_rx,
   output logic serial_c_rx,
   output logic serial_d_rx,
   // slave logic lines
   input wire logic [7:2] slave_drive,
   input wire logic [7:2] slave_oe,
   output logic slave_enable
);
   // ****************************************************************
   // bus phase tracking
   // ****************************************************************
   ppt_pkg::ppt_phase_e phase_reg, phase_next;
   logic [ppt_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic wr_reg, wr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic req;

   assign req = hsel && hready && (htrans == ppt_pkg::HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] slc_reg, slc_next;
   logic [7:0] bpd_reg, bpd_next;
   logic [7:6] sit_reg, sit_next;
   logic [7:0] spd_reg, spd_next;
   logic [7:0] spf_reg, spf_next;
   logic [3:0] ser_reg, ser_next;
   logic [7:0] split_drive;
   logic [7:0] second_rd;
   logic [7:0] byte_rd;
   logic wr_cycle;
   logic [7:0] wbyte;
   logic port_out_mode;

   assign wr_cycle = (phase_reg == ppt_pkg::PPT_DATA) && wr_reg;
   assign wbyte = hwdata[7:0];
   assign port_out_mode = slc_reg[ppt_pkg::SLC_DIR_BIT];
   assign slave_enable = |slc_reg[ppt_pkg::SLC_SLAVE_LSB +: ppt_pkg::SLC_SLAVE_W];

   function automatic logic [31:0] widen(input logic [7:0] b);
      widen = {24'h000000, b};
   endfunction

   // ****************************************************************
   // pin drive
   // ****************************************************************
   // reset leaves the control at zero: byte port undriven input
   always_comb begin
      byte_port_out = bpd_reg;
      byte_port_oe = (port_out_mode && !slave_enable) ? 8'hff : ppt_pkg::BYTE_ZERO;
   end

   // slave logic takes over lines 2-7; lines 0/1 follow serial clocks
   always_comb begin
      second_port_out = ppt_pkg::BYTE_ZERO;
      second_port_oe = ppt_pkg::BYTE_ZERO;
      if (slave_enable) begin
         second_port_out[7:2] = slave_drive;
         second_port_oe[7:2] = slave_oe;
      end else begin
         second_port_out[7:6] = sit_reg;
         second_port_oe = ppt_pkg::PB_OUT_MASK;
      end
      second_port_out[ppt_pkg::PB_LINE_ZERO] = serial_b_clk_out;
      second_port_oe[ppt_pkg::PB_LINE_ZERO] = ser_reg[ppt_pkg::SER_B_CLK_BIT];
      second_port_out[ppt_pkg::PB_LINE_ONE] = serial_a_clk_out;
      second_port_oe[ppt_pkg::PB_LINE_ONE] = ser_reg[ppt_pkg::SER_A_CLK_BIT];
   end

   ppt_line_mux #(
      .W(8)
   ) u_split_mux (
      .sel(spf_reg & ppt_pkg::EVEN_MASK),
      .reg_val(spd_reg & ppt_pkg::EVEN_MASK),
      .alt_val({1'b0, serial_a_transmit, 1'b0, serial_b_transmit,
                1'b0, serial_c_transmit, 1'b0, serial_d_transmit}),
      .drive(split_drive)
   );

   always_comb begin
      split_port_out = split_drive;
   end

   ppt_serial_rx_sel u_rx_sel (
      .alt_a(ser_reg[ppt_pkg::SER_A_ALT_BIT]),
      .alt_b(ser_reg[ppt_pkg::SER_B_ALT_BIT]),
      .split_in(split_port_in),
      .fourth_in(fourth_port_in),
      .rx_a(serial_a_rx),
      .rx_b(serial_b_rx)
   );

   always_comb begin
      serial_c_rx = split_port_in[3];
      serial_d_rx = split_port_in[1];
   end

   // ****************************************************************
   // read values
   // ****************************************************************
   always_comb begin
      byte_rd = byte_port_in;
      second_rd = (second_port_in & ppt_pkg::PB_IN_MASK)
                  | ({second_port_out[7:6], 6'h00} & ppt_pkg::PB_OUT_MASK);
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      phase_next = req ? ppt_pkg::PPT_DATA : ppt_pkg::PPT_IDLE;
      addr_next = req ? haddr : addr_reg;
      wr_next = req ? hwrite : 1'b0;
      rdata_next = rdata_reg;
      if (req && !hwrite) begin
         case (haddr)
            ppt_pkg::ADDR_SLC: rdata_next = widen(slc_reg);
            ppt_pkg::ADDR_BPD: rdata_next = widen(byte_rd);
            ppt_pkg::ADDR_SIT: rdata_next = widen(second_rd);
            ppt_pkg::ADDR_SPD: rdata_next = widen((split_port_in & ppt_pkg::ODD_MASK)
                                          | (split_drive & ppt_pkg::EVEN_MASK));
            ppt_pkg::ADDR_SER: rdata_next = {28'h0000000, ser_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      slc_next = slc_reg;
      bpd_next = bpd_reg;
      sit_next = sit_reg;
      spd_next = spd_reg;
      spf_next = spf_reg;
      ser_next = ser_reg;
      if (wr_cycle) begin
         case (addr_reg)
            ppt_pkg::ADDR_SLC: slc_next = wbyte;
            ppt_pkg::ADDR_BPD: bpd_next = wbyte;
            ppt_pkg::ADDR_SIT: sit_next = wbyte[7:6];
            ppt_pkg::ADDR_SPD: spd_next = wbyte & ppt_pkg::EVEN_MASK;
            ppt_pkg::ADDR_SPF: spf_next = wbyte & ppt_pkg::EVEN_MASK;
            ppt_pkg::ADDR_SER: ser_next = wbyte[3:0];
            default: slc_next = slc_reg;
         endcase
      end
   end

   // ****************************************************************
   // state registers
   // ****************************************************************
   // byte port data has no documented reset; zero keeps pins defined
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= ppt_pkg::PPT_IDLE;
         addr_reg <= '0;
         wr_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         slc_reg <= ppt_pkg::SLC_RESET;
         bpd_reg <= ppt_pkg::BYTE_ZERO;
         sit_reg <= 2'b00;
         spd_reg <= ppt_pkg::BYTE_ZERO;
         spf_reg <= ppt_pkg::BYTE_ZERO;
         ser_reg <= ppt_pkg::SER_RESET;
      end else begin
         phase_reg <= phase_next;
         addr_reg <= addr_next;
         wr_reg <= wr_next;
         rdata_reg <= rdata_next;
         slc_reg <= slc_next;
         bpd_reg <= bpd_next;
         sit_reg <= sit_next;
         spd_reg <= spd_next;
         spf_reg <= spf_next;
         ser_reg <= ser_next;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_write_slc(logic [7:0] v);
      wr_cycle && addr_reg == ppt_pkg::ADDR_SLC && wbyte == v;
   endsequence

   property p_port_in;
      @(posedge hclk) disable iff (!hresetn)
      s_write_slc(ppt_pkg::SLC_PORT_IN) |=> byte_port_oe == 8'h00;
   endproperty
   a_port_in: assert property (p_port_in) else $error("byte port not input");

   property p_port_out;
      @(posedge hclk) disable iff (!hresetn)
      s_write_slc(ppt_pkg::SLC_PORT_OUT) |=> byte_port_oe == 8'hff && $stable(byte_port_out);
   endproperty
   a_port_out: assert property (p_port_out) else $error("byte port not driving");

   property p_bpd_keep;
      @(posedge hclk) disable iff (!hresetn)
      !(wr_cycle && addr_reg == ppt_pkg::ADDR_BPD) |=> $stable(byte_port_out);
   endproperty
   a_bpd_keep: assert property (p_bpd_keep) else $error("byte port value lost");

   property p_bpd_read;
      @(posedge hclk) disable iff (!hresetn)
      req && !hwrite && haddr == ppt_pkg::ADDR_BPD |=> hrdata[7:0] == $past(byte_port_in);
   endproperty
   a_bpd_read: assert property (p_bpd_read) else $error("byte port read wrong");

   property p_sit_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_cycle && addr_reg == ppt_pkg::ADDR_SIT && !slave_enable
      |=> second_port_out[7:6] == $past(wbyte[7:6]);
   endproperty
   a_sit_write: assert property (p_sit_write) else $error("second port drive wrong");

   property p_tx_route;
      @(posedge hclk) disable iff (!hresetn)
      spf_reg[ppt_pkg::PC_TX_A] |-> split_port_out[ppt_pkg::PC_TX_A] == serial_a_transmit;
   endproperty
   a_tx_route: assert property (p_tx_route) else $error("transmit a not routed");

   property p_split_odd;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> (split_port_out & ppt_pkg::ODD_MASK) == 8'h00;
   endproperty
   a_split_odd: assert property (p_split_odd) else $error("odd split line driven");

   property p_clk_line;
      @(posedge hclk) disable iff (!hresetn)
      ser_reg[ppt_pkg::SER_B_CLK_BIT] |-> second_port_oe[0] && second_port_out[0] == serial_b_clk_out;
   endproperty
   a_clk_line: assert property (p_clk_line) else $error("serial clock not on line");

   property p_rx_src;
      @(posedge hclk) disable iff (!hresetn)
      ser_reg[ppt_pkg::SER_A_ALT_BIT] |-> serial_a_rx == fourth_port_in[ppt_pkg::PD_RX_A];
   endproperty
   a_rx_src: assert property (p_rx_src) else $error("receive source wrong");
endmodule

// *** bench/ppt_pin_model.sv ***
// Purpose: pin-side model of the three parallel ports and their external drivers
// Assumes: no pull resistors on any line; the bench re-randomises released levels
// Notes: a driven pin reads back its own drive, contention is not modelled
`timescale 1ns/100ps
module ppt_pin_model (
   // byte port
   input wire logic [7:0] byte_port_out,
   input wire logic [7:0] byte_port_oe,
   input wire logic [7:0] byte_ext,
   output logic [7:0] byte_port_in,
   // second port
   input wire logic [7:0] second_port_out,
   input wire logic [7:0] second_port_oe,
   input wire logic [7:0] second_ext,
   output logic [7:0] second_port_in,
   // split port
   input wire logic [7:0] split_port_out,
   input wire logic [7:0] split_ext,
   output logic [7:0] split_port_in
);
   // ****************************************************************
   // pin resolution
   // ****************************************************************
   // released lines show the outside pattern, never the last drive, so a stale
   // register cannot pass for a pin sample
   assign byte_port_in = (byte_port_oe & byte_port_out) | (~byte_port_oe & byte_ext);
   assign second_port_in = (second_port_oe & second_port_out) | (~second_port_oe & second_ext);
   // even lines are always driven, odd lines always belong to the outside
   assign split_port_in = (split_port_out & ppt_pkg::EVEN_MASK)
      | (split_ext & ppt_pkg::ODD_MASK);
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the three-port parallel block
// Assumes: zero-wait slave, single word transfers, low byte carries the register
// Notes: pin, serial transmit and slave inputs are re-randomised from a fixed seed between steps; serial clocks are set by the steps
`timescale 1ns/100ps
module tb_top;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [ppt_pkg::ADDR_W-1:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = ppt_pkg::HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   wire logic hready;
   logic [7:0] byte_port_in, byte_port_out, byte_port_oe, second_port_in;
   logic [7:0] second_port_out, second_port_oe, split_port_in, split_port_out;
   logic [7:0] byte_ext = 8'h00, second_ext = 8'h00, split_ext = 8'h00, fourth_port_in = 8'h00;
   logic [3:0] tx = 4'h0;
   logic [1:0] sclk = 2'h0;
   logic [7:2] slave_drive = 6'h00, slave_oe = 6'h00;
   logic serial_a_rx, serial_b_rx, serial_c_rx, serial_d_rx, slave_enable;
   int mismatches = 0, checks_done = 0, cycles = 0;
   integer seed = 96361;
   logic [7:0] d, fn, q;

   assign hready = hreadyout;

   ppt_ports ppt_ports_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .byte_port_in(byte_port_in),
      .byte_port_out(byte_port_out), .byte_port_oe(byte_port_oe),
      .second_port_in(second_port_in), .second_port_out(second_port_out),
      .second_port_oe(second_port_oe), .split_port_in(split_port_in),
      .split_port_out(split_port_out), .fourth_port_in(fourth_port_in),
      .serial_a_transmit(tx[3]), .serial_b_transmit(tx[2]), .serial_c_transmit(tx[1]),
      .serial_d_transmit(tx[0]), .serial_a_clk_out(sclk[1]), .serial_b_clk_out(sclk[0]),
      .serial_a_rx(serial_a_rx), .serial_b_rx(serial_b_rx), .serial_c_rx(serial_c_rx),
      .serial_d_rx(serial_d_rx), .slave_drive(slave_drive), .slave_oe(slave_oe),
      .slave_enable(slave_enable));

   ppt_pin_model ppt_pin_model_inst (.byte_port_out(byte_port_out),
      .byte_port_oe(byte_port_oe), .byte_ext(byte_ext), .byte_port_in(byte_port_in),
      .second_port_out(second_port_out), .second_port_oe(second_port_oe),
      .second_ext(second_ext), .second_port_in(second_port_in),
      .split_port_out(split_port_out), .split_ext(split_ext), .split_port_in(split_port_in));

   // ****************************************************************
   // clock, timeout, verdict
   // ****************************************************************
   initial begin
      forever #25 hclk = ~hclk;
   end

   task automatic wrap_up();
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // the whole run needs about 510 cycles; this leaves ample margin
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [ppt_pkg::ADDR_W-1:0] a,
                      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= ppt_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'h1) @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      @(posedge hclk);
      while (hready !== 1'h1) @(posedge hclk);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
      #1;
   endtask

   task automatic wr(input logic [ppt_pkg::ADDR_W-1:0] a, input logic [7:0] wd);
      logic [31:0] unused;
      bus(1'h1, a, wd, unused);
   endtask

   task automatic rd_chk(input logic [ppt_pkg::ADDR_W-1:0] a, input logic [7:0] exp);
      logic [31:0] rd;
      bus(1'h0, a, 8'h00, rd);
      chk(rd, {24'h000000, exp});
   endtask

   // new outside levels on every pin, serial transmit and slave line, launched at a rising edge
   task automatic stir();
      @(posedge hclk);
      byte_ext <= 8'($random(seed));
      second_ext <= 8'($random(seed));
      split_ext <= 8'($random(seed));
      fourth_port_in <= 8'($random(seed));
      tx <= 4'($random(seed));
      slave_drive <= 6'($random(seed));
      slave_oe <= 6'($random(seed));
      #1;
   endtask

   function automatic logic [7:0] exp_split(input logic [7:0] f, input logic [7:0] dat,
                                            input logic [3:0] t);
      logic [7:0] txv;
      txv = {1'h0, t[3], 1'h0, t[2], 1'h0, t[1], 1'h0, t[0]};
      return ((f & txv) | (~f & dat)) & ppt_pkg::EVEN_MASK;
   endfunction

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      stir();
      chk(byte_port_oe, 32'h0);
      chk(second_port_out[7:6], 32'h0);
      chk(second_port_oe[7:6], 32'h3);
      chk(split_port_out, 32'h0);
      rd_chk(ppt_pkg::ADDR_SPD, split_ext & ppt_pkg::ODD_MASK);
      rd_chk(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_RESET);
      for (int i = 0; i < 8; i++) begin
         stir();
         d = 8'($random(seed));
         wr(ppt_pkg::ADDR_BPD, d);
         chk(byte_port_oe, 32'h0);
         rd_chk(ppt_pkg::ADDR_BPD, byte_ext);
         wr(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_PORT_OUT);
         chk(byte_port_oe, 32'hff);
         chk(byte_port_out, d);
         rd_chk(ppt_pkg::ADDR_BPD, d);
         wr(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_PORT_IN);
         chk(byte_port_oe, 32'h0);
         stir();
         d = 8'($random(seed));
         wr(ppt_pkg::ADDR_SIT, d);
         chk(second_port_out[7:6], d[7:6]);
         chk(second_port_oe[7:6], 32'h3);
         rd_chk(ppt_pkg::ADDR_SIT, {d[7:6], second_ext[5:0]});
      end
      // byte port stays undriven, even with the drive bit set, while the slave owns the port
      stir();
      wr(ppt_pkg::ADDR_SLC, 8'h85);
      chk(slave_enable, 32'h1);
      chk(byte_port_oe, 32'h0);
      chk(second_port_out[7:2], slave_drive);
      chk(second_port_oe[7:2], slave_oe);
      q = ({slave_oe, 2'h0} & {slave_drive, 2'h0}) | ({~slave_oe, 2'h3} & second_ext);
      rd_chk(ppt_pkg::ADDR_SIT, {slave_drive[7:6], q[5:0]});
      wr(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_PORT_IN);
      chk(slave_enable, 32'h0);
      wr(ppt_pkg::ADDR_SER, 8'h03);
      for (int k = 0; k < 4; k++) begin
         @(posedge hclk);
         sclk <= 2'(k);
         #1;
         chk(second_port_oe[1:0], 32'h3);
         chk(second_port_out[1:0], sclk);
         rd_chk(ppt_pkg::ADDR_SIT, {d[7:6], second_ext[5:2], sclk});
      end
      wr(ppt_pkg::ADDR_SER, 8'h00);
      chk(second_port_oe[1:0], 32'h0);
      for (int k = 0; k < 4; k++) begin
         stir();
         wr(ppt_pkg::ADDR_SER, 8'(k << 2));
         chk(serial_a_rx, k[0] ? fourth_port_in[7] : split_ext[7]);
         chk(serial_b_rx, k[1] ? fourth_port_in[5] : split_ext[5]);
         chk(serial_c_rx, split_ext[3]);
         chk(serial_d_rx, split_ext[1]);
         rd_chk(ppt_pkg::ADDR_SPD, split_ext & ppt_pkg::ODD_MASK);
         rd_chk(ppt_pkg::ADDR_SER, 8'(k << 2));
      end
      for (int i = 0; i < 16; i++) begin
         stir();
         fn = {1'h0, i[3], 1'h0, i[2], 1'h0, i[1], 1'h0, i[0]};
         d = 8'($random(seed));
         wr(ppt_pkg::ADDR_SPD, d);
         wr(ppt_pkg::ADDR_SPF, fn | (8'($random(seed)) & ppt_pkg::ODD_MASK));
         q = exp_split(fn, d, tx);
         chk(split_port_out, q);
         rd_chk(ppt_pkg::ADDR_SPD, q | (split_ext & ppt_pkg::ODD_MASK));
         rd_chk(ppt_pkg::ADDR_SPF, 8'h00);
      end
      // unmapped word: write is dropped and reads as zero
      wr(10'h3fc, 8'hff);
      rd_chk(10'h3fc, 8'h00);
      rd_chk(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_PORT_IN);
      // second reset in mid-run with outputs active
      wr(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_PORT_OUT);
      wr(ppt_pkg::ADDR_SIT, 8'hc0);
      @(posedge hclk);
      hresetn <= 1'h0;
      @(posedge hclk);
      #1;
      chk(byte_port_oe, 32'h0);
      chk(second_port_out[7:6], 32'h0);
      chk(split_port_out & ppt_pkg::EVEN_MASK, 32'h0);
      @(posedge hclk);
      hresetn <= 1'h1;
      rd_chk(ppt_pkg::ADDR_SLC, ppt_pkg::SLC_RESET);
      rd_chk(ppt_pkg::ADDR_SIT, {2'h0, second_ext[5:0]});
      wrap_up();
   end
endmodule
